// ==== core/aqef_top.sv ====
// Queue completion and pause flags with enables and four interrupt request outputs
//
// Contract
// - Four request outputs, no internal priority.
// - Last-word result sets that queue's completion flag.
// - Pause-bit result sets owning queue's pause flag.
// - Each flag has its own enable bit.
// - Set flag with enable raises its request.
// - Disabled flags still set and readable.
// - Request holds until software clears flag or its enable bit.
// - Read first, then write zero to clear.
// - Event between read and write keeps flag.
// - Each source on its own output line.
`timescale 1ns/100ps
module aqef_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic result_written,
   input wire logic result_queue2,
   input wire logic result_last_ccw,
   input wire logic result_pause_bit,
   output logic queue1_complete_irq,
   output logic queue1_pause_irq,
   output logic queue2_complete_irq,
   output logic queue2_pause_irq
);
   // ************************************************************
   // Bus decode
   // ************************************************************
   logic access;
   logic hit_status;
   logic hit_enable;
   logic hit_event;
   logic status_read;
   logic status_write;
   logic enable_write;
   logic [3:0] set_strobe;
   logic [3:0] flags;
   logic [3:0] irqs;
   logic [3:0] irq_en_q;
   logic [3:0] irq_en_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pslverr_q;
   logic pslverr_d;

   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
      addr_is = (a == off);
   endfunction : addr_is

   assign access = psel && penable;
   always_comb begin
      hit_status = 1'b0;
      hit_enable = 1'b0;
      hit_event = 1'b0;
      if (addr_is(paddr, aqef_pkg::STATUS_OFFSET)) begin
         hit_status = 1'b1;
      end else if (addr_is(paddr, aqef_pkg::ENABLE_OFFSET)) begin
         hit_enable = 1'b1;
      end else if (addr_is(paddr, aqef_pkg::EVENT_OFFSET)) begin
         hit_event = 1'b1;
      end
   end

   // Zero-wait slave: every access completes in its first access cycle
   assign pready = 1'b1;
   // Arm in the setup cycle, the edge at which the read data is captured:
   // arming later would let a flag set in between be cleared unseen
   assign status_read = psel && !penable && !pwrite && hit_status;
   assign status_write = access && pwrite && hit_status;
   assign enable_write = access && pwrite && hit_enable;

   // ************************************************************
   // Enables and read data
   // ************************************************************
   always_comb begin
      irq_en_d = irq_en_q;
      if (enable_write) begin
         irq_en_d = pwdata[3:0];
      end
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      if (psel && !penable) begin
         prdata_d = aqef_pkg::READ_ZERO;
         if (!pwrite && hit_status) begin
            prdata_d[3:0] = flags;
         end else if (!pwrite && hit_enable) begin
            prdata_d[3:0] = irq_en_q;
         end
         // Event view is write-only; unmapped addresses are refused
         pslverr_d = !(hit_status || hit_enable || (hit_event && pwrite));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_q <= aqef_pkg::ENABLE_RESET;
         prdata_q <= aqef_pkg::READ_ZERO;
         pslverr_q <= 1'b0;
      end else begin
         irq_en_q <= irq_en_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q && access;

   // ************************************************************
   // Events and flag cells
   // ************************************************************
   aqef_event_decode u_decode (
      .result_written(result_written),
      .result_queue2(result_queue2),
      .result_last_ccw(result_last_ccw),
      .result_pause_bit(result_pause_bit),
      .set_strobe(set_strobe)
   );

   // Independent cells: no arbitration between the four sources
   for (genvar i = 0; i < aqef_pkg::NUM_FLAGS; i++) begin : g_flag
      aqef_flag_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .set_event(set_strobe[i]),
         .status_read(status_read),
         .clear_write(status_write),
         .write_bit(pwdata[i]),
         .irq_en(irq_en_q[i]),
         .flag(flags[i]),
         .irq(irqs[i])
      );
   end

   assign queue1_complete_irq = irqs[aqef_pkg::Q1_COMPLETE_BIT];
   assign queue1_pause_irq = irqs[aqef_pkg::Q1_PAUSE_BIT];
   assign queue2_complete_irq = irqs[aqef_pkg::Q2_COMPLETE_BIT];
   assign queue2_pause_irq = irqs[aqef_pkg::Q2_PAUSE_BIT];
endmodule : aqef_top

// ==== core/aqef_pkg.sv ====
// Package of register map, field layout and reset values for the queue event flags block
package aqef_pkg;
   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam logic [11:0] STATUS_OFFSET = 12'h000;
   localparam logic [11:0] ENABLE_OFFSET = 12'h004;
   localparam logic [11:0] EVENT_OFFSET = 12'h008;
   localparam int ADDR_WIDTH = 12;
   localparam int DATA_WIDTH = 32;
   localparam int NUM_FLAGS = 4;

   // ************************************************************
   // Field positions, shared by status, enable and event vectors
   // ************************************************************
   localparam int Q1_COMPLETE_BIT = 0;
   localparam int Q1_PAUSE_BIT = 1;
   localparam int Q2_COMPLETE_BIT = 2;
   localparam int Q2_PAUSE_BIT = 3;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [3:0] ENABLE_RESET = 4'h0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : aqef_pkg

// ==== core/aqef_event_decode.sv ====
// Maps result-written events of the sequencer onto the four flag set strobes
`timescale 1ns/100ps
module aqef_event_decode (
   input wire logic result_written,
   input wire logic result_queue2,
   input wire logic result_last_ccw,
   input wire logic result_pause_bit,
   output logic [3:0] set_strobe
);
   always_comb begin
      set_strobe = 4'h0;
      if (result_written) begin
         if (result_queue2) begin
            set_strobe[aqef_pkg::Q2_COMPLETE_BIT] = result_last_ccw;
            set_strobe[aqef_pkg::Q2_PAUSE_BIT] = result_pause_bit;
         end else begin
            set_strobe[aqef_pkg::Q1_COMPLETE_BIT] = result_last_ccw;
            set_strobe[aqef_pkg::Q1_PAUSE_BIT] = result_pause_bit;
         end
      end
   end
endmodule : aqef_event_decode

// ==== core/aqef_flag_cell.sv ====
// One sticky event flag with a read-armed clear and its own request output
`timescale 1ns/100ps
module aqef_flag_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic set_event,
   input wire logic status_read,
   input wire logic clear_write,
   input wire logic write_bit,
   input wire logic irq_en,
   output logic flag,
   output logic irq
);
   logic flag_q;
   logic flag_d;
   logic armed_q;
   logic armed_d;
   logic irq_q;
   logic irq_d;

   always_comb begin
      armed_d = armed_q;
      flag_d = flag_q;
      // Arm only when software has seen the flag set
      if (status_read) begin
         armed_d = flag_q;
      end
      if (clear_write) begin
         if (!write_bit && armed_q) begin
            flag_d = 1'b0;
         end
         armed_d = 1'b0;
      end
      // Set wins over clear, also inside the read-to-write gap
      if (set_event) begin
         flag_d = 1'b1;
         armed_d = 1'b0;
      end
      irq_d = flag_d && irq_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
         armed_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         armed_q <= armed_d;
         irq_q <= irq_d;
      end
   end

   assign flag = flag_q;
   assign irq = irq_q;
endmodule : aqef_flag_cell

// ==== verification/aqef_seq_model.sv ====
// Sequencer stand-in that posts one result event at a time
`timescale 1ns/100ps
module aqef_seq_model (
   input wire logic pclk,
   output logic result_written = 1'b0,
   output logic result_queue2 = 1'b0,
   output logic result_last_ccw = 1'b0,
   output logic result_pause_bit = 1'b0
);
   // Source code: bit1 picks queue 2, bit0 a pause word instead of the last word
   task automatic post(input logic [1:0] src);
      @(posedge pclk);
      result_written <= 1'b1;
      result_queue2 <= src[1];
      result_last_ccw <= ~src[0];
      result_pause_bit <= src[0];
      @(posedge pclk);
      // Qualifiers flip after the pulse so stale levels never look valid
      result_written <= 1'b0;
      result_queue2 <= ~src[1];
      result_last_ccw <= src[0];
      result_pause_bit <= ~src[0];
   endtask : post
endmodule : aqef_seq_model

// ==== verification/aqef_monitor.sv ====
// Checker of the request lines and bus answers
`timescale 1ns/100ps
module aqef_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic result_written,
   input wire logic result_queue2,
   input wire logic result_last_ccw,
   input wire logic result_pause_bit,
   input wire logic queue1_complete_irq,
   input wire logic queue1_pause_irq,
   input wire logic queue2_complete_irq,
   input wire logic queue2_pause_irq
);
   logic [3:0] irq_v, src;
   logic wr;
   assign irq_v = {queue2_pause_irq, queue2_complete_irq, queue1_pause_irq, queue1_complete_irq};
   assign src = {4{result_written}} & {result_queue2 & result_pause_bit,
      result_queue2 & result_last_ccw, !result_queue2 & result_pause_bit,
      !result_queue2 & result_last_ccw};
   assign wr = psel && penable && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A request may also rise when software enables a flag already set
   // The enable is registered first, so that rise comes two edges after the write
   a_q1c_cause: assert property ($rose(irq_v[0]) |-> $past(src[0]) || $past(wr, 2))
      else $error("q1 complete rose");
   a_q1p_cause: assert property ($rose(irq_v[1]) |-> $past(src[1]) || $past(wr, 2))
      else $error("q1 pause rose");
   a_q2c_cause: assert property ($rose(irq_v[2]) |-> $past(src[2]) || $past(wr, 2))
      else $error("q2 complete rose");
   a_q2p_cause: assert property ($rose(irq_v[3]) |-> $past(src[3]) || $past(wr, 2))
      else $error("q2 pause rose");
   // A cleared enable drops its request two edges after the write
   a_irq_hold: assert property (!wr && !$past(wr) |=> (irq_v & $past(irq_v)) == $past(irq_v))
      else $error("request dropped");
   a_rst_quiet: assert property ($rose(presetn) |-> irq_v == 4'h0)
      else $error("request after reset");
   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("wait state");
   a_err_access: assert property (!(psel && penable) |-> !pslverr)
      else $error("error outside access");
endmodule : aqef_monitor
bind aqef_top aqef_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
   .result_written, .result_queue2, .result_last_ccw, .result_pause_bit,
   .queue1_complete_irq, .queue1_pause_irq, .queue2_complete_irq, .queue2_pause_irq);

// ==== verification/tb.sv ====
// Directed APB bench of the queue event flags block
`timescale 1ns/100ps
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, result_written, result_queue2, result_last_ccw, result_pause_bit;
   wire [3:0] irq;
   int miscompares = 0;
   int samples_checked = 0;
   always #2 pclk = ~pclk;
   aqef_seq_model seq (.pclk, .result_written, .result_queue2, .result_last_ccw,
      .result_pause_bit);
   aqef_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .result_written, .result_queue2, .result_last_ccw, .result_pause_bit,
      .queue1_complete_irq(irq[0]), .queue1_pause_irq(irq[1]),
      .queue2_complete_irq(irq[2]), .queue2_pause_irq(irq[3]));
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk
   task automatic see(input logic [3:0] e);
      @(negedge pclk);
      chk({28'h0, irq}, {28'h0, e});
   endtask : see
   initial begin
      repeat (3000) @(posedge pclk);
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      see(4'h0);
      rdchk(12'h004, 32'h0);
      seq.post(2'd0);
      see(4'h0);
      // Zero write with no read first must not clear
      apb(1'b1, 12'h000, 32'h0);
      rdchk(12'h000, 32'h1);
      apb(1'b1, 12'h004, 32'h2);
      seq.post(2'd1);
      see(4'h2);
      rdchk(12'h000, 32'h3);
      apb(1'b1, 12'h000, 32'h1);
      see(4'h0);
      rdchk(12'h000, 32'h1);
      apb(1'b1, 12'h000, 32'h0);
      // Unmapped offset is refused with an error and changes nothing
      apb(1'b1, 12'h00c, 32'hf);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, 12'h004, 32'hf);
      chk({31'h0, err}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         seq.post(i[1:0]);
         rdchk(12'h000, 32'h1 << i);
         see(4'h1 << i);
         apb(1'b1, 12'h000, 32'h0);
         see(4'h0);
      end
      rdchk(12'h004, 32'hf);
      seq.post(2'd3);
      rdchk(12'h000, 32'h8);
      seq.post(2'd3);
      apb(1'b1, 12'h000, 32'h0);
      see(4'h8);
      // Event lands on the read's setup edge: unseen, so the zero write keeps it
      fork
         rdchk(12'h000, 32'h8);
         seq.post(2'd0);
      join
      apb(1'b1, 12'h000, 32'h0);
      see(4'h1);
      print_verdict();
   end
endmodule : tb
